// >>> ffint_pkg.sv
/*
 * Package for the forced-interrupt logic of the floppy controller:
 * register offsets, field positions, reset values and packed carriers.
 * Assumes a single 40 MHz clock domain and an 8-bit register port.
 */
package ffint_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam logic [2:0] FFINT_ADDR_CMD    = 3'h0; // Write: command
    localparam logic [2:0] FFINT_ADDR_STATUS = 3'h0; // Read: controller status
    localparam logic [2:0] FFINT_ADDR_EVT    = 3'h1; // Read: sticky events, clear on read
    localparam logic [2:0] FFINT_ADDR_MASK   = 3'h2; // Read/write: event mask
    localparam logic [2:0] FFINT_ADDR_COND   = 3'h3; // Read: armed conditions

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    localparam logic [3:0] FFINT_OPC_FORCE   = 4'hd; // Upper nibble of forced interrupt
    localparam int         FFINT_CMD_OPC_HI  = 7;
    localparam int         FFINT_CMD_OPC_LO  = 4;
    localparam int         FFINT_BIT_NRDY_RDY = 0;   // Not-ready to ready
    localparam int         FFINT_BIT_RDY_NRDY = 1;   // Ready to not-ready
    localparam int         FFINT_BIT_INDEX    = 2;   // Every index pulse
    localparam int         FFINT_BIT_IMMED    = 3;   // Immediate

    // ------------------------------------------------------------
    // Status and event bits
    // ------------------------------------------------------------
    localparam int FFINT_STS_BUSY  = 0;
    localparam int FFINT_STS_READY = 7;
    localparam int FFINT_EVT_COND  = 0; // A selected condition fired
    localparam int FFINT_EVT_ABORT = 1; // A running command was aborted
    localparam int FFINT_EVT_DONE  = 2; // Ordinary command completed

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] FFINT_COND_RST = 4'h0;
    localparam logic [2:0] FFINT_MASK_RST = 3'h0;
    localparam logic [2:0] FFINT_EVT_RST  = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       imm;        // Immediate interrupt
        logic       index;      // Every index pulse
        logic       rdy_nrdy;   // Ready to not-ready
        logic       nrdy_rdy;   // Not-ready to ready
    } ffint_cond_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ffint_bus_type;

endpackage : ffint_pkg

// >>> ffint_sync.sv
/*
 * Two-flop synchroniser with a registered copy of the settled level.
 * Assumes the input is asynchronous to CLK_I.
 */
`timescale 1ns/1ps
module ffint_sync (
    input  wire logic CLK_I,
    input  wire logic RST_I,
    input  wire logic async_i,
    output logic      level_o,
    output logic      prev_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First flop feeds only the second
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign prev_o  = prev_q;
endmodule : ffint_sync

// >>> ffint_top.sv
/*
 * Forced-interrupt logic of the floppy controller: command decode,
 * abort of the running command, condition arming and the request line.
 * Assumes a host on a plain strobe port in the CLK_I domain, and drive
 * ready and index arriving asynchronously from the drive cable.
 */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// [RL1] The low command nibble arms not-ready-to-ready, ready-to-not-ready, every-index and immediate conditions.
// [RL2] Loading a forced interrupt aborts any running command at once and clears busy.
// [RL3] The request goes high when an armed condition later occurs; only set bits arm a condition.
// [RL4] A forced interrupt with a zero nibble aborts without ever raising the request.
// [RL5] A pending non-immediate request clears on a status read or a command write.
// [RL6] Immediate raises the request at once and holds it until a zero-nibble forced interrupt.
// [RL7] Several armed conditions combine as a logical OR.
// [RL8] Ready changes and index leading edges are found on synchronised samples, once per event.
module ffint_top
    import ffint_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic [7:0]      RDATA_O,
    input  wire logic       DRIVE_READY_I,
    input  wire logic       INDEX_I,
    input  wire logic       CMD_DONE_I,
    output logic            CMD_START_O,
    output logic            CMD_ABORT_O,
    output logic            BUSY_O,
    output logic            IRQ_REQUEST_OUT_O,
    output logic            IRQ_O
);
    import ffint_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    ffint_bus_type  bus;
    logic           cmd_wr;
    logic           status_rd;
    logic           evt_rd;
    logic           is_force;
    ffint_cond_type new_cond;

    assign bus.wr    = WR_I;
    assign bus.rd    = RD_I;
    assign bus.addr  = ADDR_I;
    assign bus.wdata = WDATA_I;

    // Command port and status port share one offset
    assign cmd_wr    = bus.wr && (bus.addr == FFINT_ADDR_CMD);
    assign status_rd = bus.rd && (bus.addr == FFINT_ADDR_STATUS);
    assign evt_rd    = bus.rd && (bus.addr == FFINT_ADDR_EVT);
    assign is_force  = cmd_wr && (bus.wdata[FFINT_CMD_OPC_HI:FFINT_CMD_OPC_LO] == FFINT_OPC_FORCE);

    // Nibble to condition enables
    assign new_cond.nrdy_rdy = bus.wdata[FFINT_BIT_NRDY_RDY]; // RL1
    assign new_cond.rdy_nrdy = bus.wdata[FFINT_BIT_RDY_NRDY]; // RL1
    assign new_cond.index    = bus.wdata[FFINT_BIT_INDEX];    // RL1
    assign new_cond.imm      = bus.wdata[FFINT_BIT_IMMED];    // RL1

    // ------------------------------------------------------------
    // Drive inputs
    // ------------------------------------------------------------
    logic ready_now;
    logic ready_prev;
    logic index_now;
    logic index_prev;
    logic ev_nrdy_rdy;
    logic ev_rdy_nrdy;
    logic ev_index;

    ffint_sync u_sync_ready (
        .CLK_I   (CLK_I),
        .RST_I   (RST_I),
        .async_i (DRIVE_READY_I),
        .level_o (ready_now),
        .prev_o  (ready_prev)
    );

    ffint_sync u_sync_index (
        .CLK_I   (CLK_I),
        .RST_I   (RST_I),
        .async_i (INDEX_I),
        .level_o (index_now),
        .prev_o  (index_prev)
    );

    // One-cycle event per transition, never per level
    assign ev_nrdy_rdy = ready_now && !ready_prev;  // RL8
    assign ev_rdy_nrdy = !ready_now && ready_prev;  // RL8
    assign ev_index    = index_now && !index_prev;  // RL8

    // ------------------------------------------------------------
    // Armed conditions
    // ------------------------------------------------------------
    ffint_cond_type cond_q;
    logic           cond_hit;

    // Each forced interrupt replaces the armed set; zero disarms all
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cond_q <= FFINT_COND_RST;
        end else if (is_force) begin
            cond_q <= new_cond; // RL1
        end
    end

    // Only armed edge conditions count, ORed together
    assign cond_hit = (cond_q.nrdy_rdy && ev_nrdy_rdy)
                    || (cond_q.rdy_nrdy && ev_rdy_nrdy)
                    || (cond_q.index && ev_index); // RL3 RL7

    // ------------------------------------------------------------
    // Busy and command sequencing
    // ------------------------------------------------------------
    logic busy_q;
    logic start_q;
    logic abort_q;

    // Forced interrupt never starts a command; it kills one
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_q <= 1'b0;
        end else if (is_force) begin
            busy_q <= 1'b0; // RL2 RL4
        end else if (cmd_wr) begin
            busy_q <= 1'b1;
        end else if (CMD_DONE_I) begin
            busy_q <= 1'b0;
        end
    end

    // Start and abort pulses to the command engine
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            start_q <= cmd_wr && !is_force;
            abort_q <= is_force; // RL2
        end
    end

    assign CMD_START_O = start_q;
    assign CMD_ABORT_O = abort_q;
    assign BUSY_O      = busy_q;

    // ------------------------------------------------------------
    // Request line
    // ------------------------------------------------------------
    logic req_q;
    logic imm_hold_q;

    // Immediate latch survives reads and writes; only a zero nibble frees it
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            imm_hold_q <= 1'b0;
        end else if (is_force && new_cond.imm) begin
            imm_hold_q <= 1'b1; // RL6
        end else if (is_force && (bus.wdata[3:0] == 4'h0)) begin
            imm_hold_q <= 1'b0; // RL6
        end
    end

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            req_q <= 1'b0;
        end else if (cond_hit || (CMD_DONE_I && busy_q && !is_force)) begin
            req_q <= 1'b1; // RL3
        end else if (is_force) begin
            req_q <= 1'b0; // RL4
        end else if (status_rd || cmd_wr) begin
            req_q <= 1'b0; // RL5
        end
    end

    assign IRQ_REQUEST_OUT_O = req_q || imm_hold_q; // RL6 RL7

    // ------------------------------------------------------------
    // Sticky events, mask and interrupt
    // ------------------------------------------------------------
    logic [2:0] evt_q;
    logic [2:0] mask_q;
    logic [2:0] evt_set;

    assign evt_set[FFINT_EVT_COND]  = cond_hit || (is_force && new_cond.imm);
    assign evt_set[FFINT_EVT_ABORT] = is_force && busy_q;
    assign evt_set[FFINT_EVT_DONE]  = CMD_DONE_I && busy_q && !is_force;

    // Read clears, but a new event in the same cycle stays set
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            evt_q <= FFINT_EVT_RST;
        end else if (evt_rd) begin
            evt_q <= evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    // Mask written by software
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mask_q <= FFINT_MASK_RST;
        end else if (bus.wr && (bus.addr == FFINT_ADDR_MASK)) begin
            mask_q <= bus.wdata[2:0];
        end
    end

    assign IRQ_O = |(evt_q & mask_q);

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] rdata_q;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            if (bus.addr == FFINT_ADDR_STATUS) begin
                rdata_q <= {ready_now, 6'h00, busy_q};
            end else if (bus.addr == FFINT_ADDR_EVT) begin
                rdata_q <= {5'h00, evt_q};
            end else if (bus.addr == FFINT_ADDR_MASK) begin
                rdata_q <= {5'h00, mask_q};
            end else if (bus.addr == FFINT_ADDR_COND) begin
                rdata_q <= {4'h0, cond_q};
            end else begin
                rdata_q <= 8'h00; // Unmapped reads zero
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA_O = rdata_q;

endmodule : ffint_top

// >>> ffint_host.sv
/* Host processor model driving the register port of ffint_top.
   Assumes the slave never stalls and read data follow by one cycle. */
`timescale 1ns/1ps
module ffint_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic [2:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    // Idle bus at time zero
    initial begin
        addr_o = 3'h7;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // One-cycle write; data parked inverted so nothing stale looks valid
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    // One-cycle read; data taken in the following cycle only
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask : rd
endmodule : ffint_host

// >>> ffint_top_sva.sv
/* Checker on the ports of ffint_top.
   Assumes drive pins hold each level for several cycles. */
`timescale 1ns/1ps
module ffint_top_sva
    import ffint_pkg::*;
(
    input wire logic       CLK_I,
    input wire logic       RST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic       DRIVE_READY_I,
    input wire logic       INDEX_I,
    input wire logic       CMD_DONE_I,
    input wire logic       CMD_ABORT_O,
    input wire logic       BUSY_O,
    input wire logic       IRQ_REQUEST_OUT_O
);
    logic       imm_q;
    logic [3:0] arm_q;
    logic [3:0] quiet_q;
    wire        fw = WR_I && ADDR_I == 3'h0 && WDATA_I[7:4] == FFINT_OPC_FORCE;
    wire        cw = WR_I && ADDR_I == 3'h0 && !fw;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // Armed nibble; immediate survives until a zero nibble
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            imm_q <= 1'b0;
            arm_q <= 4'h0;
        end else if (fw) begin
            imm_q <= (WDATA_I[3:0] != 4'h0) && (imm_q || WDATA_I[3]);
            arm_q <= WDATA_I[3:0];
        end
    end

    // Cycles since any pin event; in-flight events make clears ambiguous
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) quiet_q <= 4'h0;
        else if ($changed(DRIVE_READY_I) || $changed(INDEX_I) || CMD_DONE_I) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end

    sequence s_imm_load;
        fw && WDATA_I[3];
    endsequence
    sequence s_event;
        ($rose(DRIVE_READY_I) && arm_q[0]) || ($fell(DRIVE_READY_I) && arm_q[1]) || ($rose(INDEX_I) && arm_q[2]);
    endsequence

    a_abort_idle: assert property (fw |=> CMD_ABORT_O && !BUSY_O)
        else $error("forced write did not abort");
    a_zero_silent: assert property (fw && WDATA_I[3:0] == 4'h0 && quiet_q > 4'h5 |=> !IRQ_REQUEST_OUT_O [*2])
        else $error("zero nibble raised request");
    a_immed_rise: assert property (s_imm_load |=> IRQ_REQUEST_OUT_O)
        else $error("immediate did not raise request");
    a_immed_hold: assert property (imm_q |-> IRQ_REQUEST_OUT_O)
        else $error("immediate request dropped");
    a_status_clear: assert property (RD_I && ADDR_I == 3'h0 && !imm_q && quiet_q > 4'h5 |=> !IRQ_REQUEST_OUT_O)
        else $error("status read left request");
    a_cmd_clear: assert property (cw && !imm_q && quiet_q > 4'h5 |=> !IRQ_REQUEST_OUT_O)
        else $error("command write left request");
    a_cond_fire: assert property (s_event |-> ##[2:6] IRQ_REQUEST_OUT_O)
        else $error("armed condition did not fire");
    a_quiet_idle: assert property (arm_q == 4'h0 && quiet_q > 4'h5 && !$past(WR_I) |-> !$rose(IRQ_REQUEST_OUT_O))
        else $error("request rose without cause");
endmodule : ffint_top_sva

bind ffint_top ffint_top_sva ffint_top_sva_inst (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .DRIVE_READY_I(DRIVE_READY_I), .INDEX_I(INDEX_I),
    .CMD_DONE_I(CMD_DONE_I), .CMD_ABORT_O(CMD_ABORT_O), .BUSY_O(BUSY_O), .IRQ_REQUEST_OUT_O(IRQ_REQUEST_OUT_O));

// >>> testbench.sv
/* Self-checking bench for ffint_top; the host model drives the register
   port, drive pins and the command engine are driven here. */
`timescale 1ns/1ps
module testbench;
    import ffint_pkg::*;
    logic        clk, rst, rdy, idx, done, wr, rd, start, abort, busy, req, irq, e;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, rd_v, cmd;
    logic [31:0] seed;
    int          mismatches, checked;
    logic [3:0]  nib_t [6] = '{4'h1, 4'h2, 4'h6, 4'h1, 4'h4, 4'h2};
    logic        idx_t [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    ffint_top ffint_top_inst (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .DRIVE_READY_I(rdy), .INDEX_I(idx), .CMD_DONE_I(done), .CMD_START_O(start),
        .CMD_ABORT_O(abort), .BUSY_O(busy), .IRQ_REQUEST_OUT_O(req), .IRQ_O(irq));
    ffint_host ffint_host_inst (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    // Which condition an event hits
    function logic fires(input logic [3:0] nib, input logic is_idx, input logic new_rdy);
        return is_idx ? nib[2] : (new_rdy ? nib[0] : nib[1]);
    endfunction : fires
    task report_and_stop();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chkb(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask : chkb
    task settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : settle
    // Bounded wait; a hang ends the run
    task wait_req();
        for (int i = 0; i < 12 && req !== 1'b1; i++) @(posedge clk);
        #1;
        chkb(req, 1'b1);
        if (req !== 1'b1) report_and_stop();
    endtask : wait_req

    initial begin
        rst = 1'b1;
        rdy = 1'b0;
        idx = 1'b0;
        done = 1'b0;
        seed = 32'hb676;
        mismatches = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle(8);
        ffint_host_inst.wr(3'h2, 8'h07);
        cmd = xs();
        if (cmd[7:4] == FFINT_OPC_FORCE) cmd[7:4] = 4'h0;
        ffint_host_inst.wr(3'h0, cmd);
        #1 chkb(start, 1'b1);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        wait_req();
        settle(8);
        ffint_host_inst.rd(3'h0, rd_v);
        chk(rd_v, {rdy, 6'h00, 1'b0});
        settle(1);
        chkb(req, 1'b0);
        ffint_host_inst.wr(3'h0, cmd);
        #1 chkb(busy, 1'b1);
        ffint_host_inst.wr(3'h0, 8'hd0);
        #1 chkb(abort, 1'b1);
        chkb(busy, 1'b0);
        settle(6);
        chkb(req, 1'b0);
        chkb(irq, 1'b1);
        ffint_host_inst.rd(3'h1, rd_v);
        chk(rd_v, 8'h06);
        ffint_host_inst.rd(3'h2, rd_v);
        chk(rd_v, 8'h07);
        chkb(irq, 1'b0);
        // Each edge condition armed alone or paired and hit; not-ready-to-ready and index also missed
        for (int k = 0; k < 6; k++) begin
            ffint_host_inst.wr(3'h0, {FFINT_OPC_FORCE, nib_t[k]});
            settle(2);
            e = fires(nib_t[k], idx_t[k], ~rdy);
            @(posedge clk);
            if (idx_t[k]) idx <= 1'b1;
            else rdy <= ~rdy;
            if (e) begin
                wait_req();
                settle(8);
                ffint_host_inst.rd(3'h0, rd_v);
                settle(2);
                chkb(req, 1'b0);
            end else begin
                settle(8);
                chkb(req, 1'b0);
            end
            @(posedge clk) idx <= 1'b0;
            settle(8);
            chkb(req, 1'b0);
        end
        // Immediate survives reads and command writes
        ffint_host_inst.wr(3'h0, 8'hd8);
        #1 chkb(req, 1'b1);
        ffint_host_inst.rd(3'h0, rd_v);
        ffint_host_inst.wr(3'h0, cmd);
        settle(2);
        chkb(req, 1'b1);
        ffint_host_inst.rd(3'h1, rd_v);
        chk(rd_v & 8'h01, 8'h01);
        ffint_host_inst.rd(3'h3, rd_v);
        chk(rd_v, 8'h08);
        ffint_host_inst.wr(3'h0, 8'hd0);
        #1 chkb(req, 1'b0);
        ffint_host_inst.rd(3'h5, rd_v);
        chk(rd_v, 8'h00);
        report_and_stop();
    end
endmodule : testbench
